//--- design/ccmcfg_pkg.sv
// Package: register map, field layout, reset values and encodings of the cipher configuration block
package ccmcfg_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_ENGINE_ENABLE   = 12'h0500;
   localparam logic [11:0] OFS_OPERATION_MODE  = 12'h0504;
   localparam logic [11:0] OFS_KEY_NONCE_PTR   = 12'h0508;
   localparam logic [11:0] OFS_SOURCE_PTR      = 12'h050c;
   localparam logic [11:0] OFS_RESULT_PTR      = 12'h0510;
   localparam logic [11:0] OFS_WORK_AREA_PTR   = 12'h0514;
   localparam logic [11:0] OFS_MAX_PAYLOAD     = 12'h0518;
   localparam logic [11:0] OFS_RATE_SUBST      = 12'h051c;
   localparam logic [11:0] OFS_TASKS           = 12'h0000;
   localparam logic [11:0] OFS_STATUS          = 12'h0004;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int ENABLE_LSB   = 0;
   localparam int ENABLE_W     = 2;
   localparam int DIR_BIT      = 0;
   localparam int RATE_LSB     = 16;
   localparam int RATE_W       = 2;
   localparam int LEN_BIT      = 24;
   localparam int MAXP_W       = 8;
   localparam int TASK_KS_BIT  = 0;
   localparam int TASK_CP_BIT  = 1;
   localparam int TASK_RO_BIT  = 2;
   // ------------------------------------------------------------
   // Values and reset values
   // ------------------------------------------------------------
   localparam logic [1:0]  ENABLE_OFF      = 2'h0;
   localparam logic [1:0]  ENABLE_ON       = 2'h2;
   localparam logic [31:0] RST_ENABLE      = 32'h0000_0000;
   localparam logic [31:0] RST_MODE        = 32'h0000_0001;
   localparam logic [31:0] RST_PTR         = 32'h0000_0000;
   localparam logic [7:0]  RST_MAX_PAYLOAD = 8'hfb;
   localparam logic [1:0]  RST_RATE_SUBST  = 2'h0;
   localparam logic [7:0]  DEFAULT_PAYLOAD = 8'h1b;
   localparam logic [7:0]  WORK_HEADER     = 8'h10;
   localparam logic [4:0]  LEN_MASK_SHORT  = 5'h1f;
   localparam logic        DIR_ENCRYPT     = 1'b0;
   localparam logic        DIR_DECRYPT     = 1'b1;
   // Rate codes: 0 1 Mbps, 1 2 Mbps, 2 125 kbps, 3 500 kbps
   localparam logic [1:0]  RATE_1M         = 2'h0;
   localparam logic [1:0]  RATE_2M         = 2'h1;
   localparam logic [1:0]  RATE_125K       = 2'h2;
   localparam logic [1:0]  RATE_500K       = 2'h3;
   // Cycles per keystream byte at 125 MHz, byte time on air
   localparam int CLK_MHZ       = 125;
   localparam int BYTE_NS_1M    = 8000;
   localparam int BYTE_NS_2M    = 4000;
   localparam int BYTE_NS_125K  = 64000;
   localparam int BYTE_NS_500K  = 16000;
   localparam int NS_PER_US     = 1000;
   localparam int CYC_1M    = BYTE_NS_1M * CLK_MHZ / NS_PER_US;
   localparam int CYC_2M    = BYTE_NS_2M * CLK_MHZ / NS_PER_US;
   localparam int CYC_125K  = BYTE_NS_125K * CLK_MHZ / NS_PER_US;
   localparam int CYC_500K  = BYTE_NS_500K * CLK_MHZ / NS_PER_US;
endpackage : ccmcfg_pkg

//--- design/ccmcfg_pace.sv
// Rate pacer: one-cycle enable pulse per byte time of the selected radio rate
`timescale 1ns/1ps
module ccmcfg_pace #(
   parameter int CNT_W = 14
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Control
   input  wire logic             run,
   input  wire logic [1:0]       rate,
   // Pulse
   output logic                  tick
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic             tick;
   } ccmcfg_pace_t;

   ccmcfg_pace_t st;
   ccmcfg_pace_t next_st;

   function automatic logic [CNT_W-1:0] period(input logic [1:0] r);
      case (r)
         ccmcfg_pkg::RATE_2M:   period = CNT_W'(ccmcfg_pkg::CYC_2M - 1);
         ccmcfg_pkg::RATE_125K: period = CNT_W'(ccmcfg_pkg::CYC_125K - 1);
         ccmcfg_pkg::RATE_500K: period = CNT_W'(ccmcfg_pkg::CYC_500K - 1);
         default:               period = CNT_W'(ccmcfg_pkg::CYC_1M - 1);
      endcase
   endfunction : period

   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      if (!run) begin
         next_st.cnt = period(rate);
      end else if (st.cnt == '0) begin
         next_st.cnt  = period(rate);
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick && run;
endmodule : ccmcfg_pace

//--- design/ccmcfg_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ccmcfg_buf #(
   parameter int WIDTH = 32
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] mem;
      logic                  rd;
      logic                  wr;
      logic [1:0]            cnt;
   } ccmcfg_buf_t;

   ccmcfg_buf_t st;
   ccmcfg_buf_t next_st;
   logic        push;
   logic        pop;

   always_comb begin
      next_st = st;
      push    = in_valid && (st.cnt != 2'd2);
      pop     = out_ready && (st.cnt != 2'd0);
      if (push) begin
         next_st.mem[st.wr] = in_data;
         next_st.wr         = ~st.wr;
      end
      if (pop) begin
         next_st.rd = ~st.rd;
      end
      next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Full stalls the source, so a receiver stall loses no word
   assign in_ready  = (st.cnt != 2'd2);
   assign out_valid = (st.cnt != 2'd0);
   assign out_data  = st.mem[st.rd];
endmodule : ccmcfg_buf

//--- design/ccmcfg_top.sv
// Cipher configuration registers, task sampling and keystream request sequencer
// Function
// - Engine runs only with enable field at 2, off at 0, resets off.
// - Direction 0 encrypts, 1 decrypts; reset selects decryption.
// - Mode settings are sampled when keystream or cipher task fires.
// - Rate field paces engine: 0 1M, 1 2M, 2 125k, 3 500k.
// - Length format 0: 5-bit length, keystream up to 27 bytes.
// - Length format 1: 8-bit length, keystream up to maximum payload size.
// - Key and nonce fetched from the key-nonce pointer.
// - Work area pointer holds intermediate data of all passes; the sequencer never requests it, and only APB reads it back.
// - Extended keystream length set by max payload, reset 251.
// - Rate-substitute task uses stored override rate instead of field.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module ccmcfg_top #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Memory request stream
   output logic                   mem_valid,
   input  wire logic              mem_ready,
   output logic [31:0]            mem_addr,
   // Engine settings for the current operation
   output logic                   engine_on,
   output logic                   op_decrypt,
   output logic                   op_extended,
   output logic [1:0]             op_rate,
   output logic [7:0]             op_length,
   output logic                   byte_tick,
   output logic                   op_busy
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_KEY  = 4'b0010,
      S_SRC  = 4'b0100,
      S_DST  = 4'b1000
   } ccmcfg_seq_t;

   typedef struct packed {
      // Software fields
      logic [1:0]  enable;
      logic        dir;
      logic [1:0]  rate;
      logic        len_fmt;
      logic [31:0] key_ptr;
      logic [31:0] src_ptr;
      logic [31:0] dst_ptr;
      logic [31:0] work_ptr;
      logic [7:0]  max_payload;
      logic [1:0]  rate_subst;
      logic        subst_armed;
      // Sampled at task
      logic        s_dir;
      logic        s_len;
      logic [1:0]  s_rate;
      logic [7:0]  s_length;
      // Sequencer, read path
      ccmcfg_seq_t seq;
      logic [31:0] rd_data;
   } ccmcfg_top_t;

   ccmcfg_top_t st;
   ccmcfg_top_t next_st;

   logic        wr_en;
   logic        rd_en;
   logic        task_ks;
   logic        task_cp;
   logic        task_ro;
   logic        req_valid;
   logic        req_ready;
   logic [31:0] req_addr;
   logic        run;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction : hit

   // Keystream length in bytes for a format
   function automatic logic [7:0] ks_len(input logic ext, input logic [7:0] maxp);
      ks_len = ext ? maxp : ccmcfg_pkg::DEFAULT_PAYLOAD;
   endfunction : ks_len

   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;
   assign task_ks = wr_en && hit(paddr, ccmcfg_pkg::OFS_TASKS) && pwdata[ccmcfg_pkg::TASK_KS_BIT];
   assign task_cp = wr_en && hit(paddr, ccmcfg_pkg::OFS_TASKS) && pwdata[ccmcfg_pkg::TASK_CP_BIT];
   assign task_ro = wr_en && hit(paddr, ccmcfg_pkg::OFS_TASKS) && pwdata[ccmcfg_pkg::TASK_RO_BIT];
   assign run     = (st.enable == ccmcfg_pkg::ENABLE_ON);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_st   = st;
      req_valid = 1'b0;
      req_addr  = '0;
      if (wr_en) begin
         if (hit(paddr, ccmcfg_pkg::OFS_ENGINE_ENABLE)) begin
            next_st.enable = pwdata[ccmcfg_pkg::ENABLE_LSB +: ccmcfg_pkg::ENABLE_W];
         end

         if (hit(paddr, ccmcfg_pkg::OFS_OPERATION_MODE)) begin
            next_st.dir     = pwdata[ccmcfg_pkg::DIR_BIT];
            next_st.rate    = pwdata[ccmcfg_pkg::RATE_LSB +: ccmcfg_pkg::RATE_W];
            next_st.len_fmt = pwdata[ccmcfg_pkg::LEN_BIT];
         end

         if (hit(paddr, ccmcfg_pkg::OFS_KEY_NONCE_PTR)) begin
            next_st.key_ptr = pwdata;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_SOURCE_PTR)) begin
            next_st.src_ptr = pwdata;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_RESULT_PTR)) begin
            next_st.dst_ptr = pwdata;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_WORK_AREA_PTR)) begin
            next_st.work_ptr = pwdata;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_MAX_PAYLOAD)) begin
            next_st.max_payload = pwdata[ccmcfg_pkg::MAXP_W-1:0];
         end

         if (hit(paddr, ccmcfg_pkg::OFS_RATE_SUBST)) begin
            next_st.rate_subst = pwdata[ccmcfg_pkg::RATE_W-1:0];
         end
      end

      if (task_ro) begin
         next_st.subst_armed = 1'b1;
      end

      // Keystream and cipher tasks are ignored while off or already busy
      if ((task_ks || task_cp) && run && st.seq == S_IDLE) begin
         next_st.s_dir    = st.dir;
         next_st.s_len    = st.len_fmt;
         next_st.s_rate   = st.subst_armed ? st.rate_subst : st.rate;
         next_st.s_length = ks_len(st.len_fmt, st.max_payload);
         next_st.subst_armed = task_ro;
         next_st.seq      = S_KEY;
      end

      // Pointer requests go out in fixed order, one per accepted word
      case (st.seq)
         S_IDLE: begin
         end
         S_KEY: begin
            req_valid = 1'b1;
            req_addr  = st.key_ptr;
            if (req_ready) begin
               next_st.seq = S_SRC;
            end
         end
         S_SRC: begin
            req_valid = 1'b1;
            req_addr  = st.src_ptr;
            if (req_ready) begin
               next_st.seq = S_DST;
            end
         end
         S_DST: begin
            req_valid = 1'b1;
            req_addr  = st.dst_ptr;
            if (req_ready) begin
               next_st.seq = S_IDLE;
            end
         end
         default: begin
            next_st.seq = S_IDLE;
         end
      endcase

      // Switching off abandons the sequence
      if (!run && !(wr_en && hit(paddr, ccmcfg_pkg::OFS_ENGINE_ENABLE)
                    && pwdata[1:0] == ccmcfg_pkg::ENABLE_ON)) begin
         next_st.seq = S_IDLE;
      end

      // Read data is captured in setup, so the access phase needs no wait
      if (rd_en) begin
         next_st.rd_data = '0;
         if (hit(paddr, ccmcfg_pkg::OFS_ENGINE_ENABLE)) begin
            next_st.rd_data[ccmcfg_pkg::ENABLE_LSB +: ccmcfg_pkg::ENABLE_W] = st.enable;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_OPERATION_MODE)) begin
            next_st.rd_data[ccmcfg_pkg::DIR_BIT] = st.dir;
            next_st.rd_data[ccmcfg_pkg::RATE_LSB +: ccmcfg_pkg::RATE_W] = st.rate;
            next_st.rd_data[ccmcfg_pkg::LEN_BIT] = st.len_fmt;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_KEY_NONCE_PTR)) begin
            next_st.rd_data = st.key_ptr;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_SOURCE_PTR)) begin
            next_st.rd_data = st.src_ptr;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_RESULT_PTR)) begin
            next_st.rd_data = st.dst_ptr;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_WORK_AREA_PTR)) begin
            next_st.rd_data = st.work_ptr;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_MAX_PAYLOAD)) begin
            next_st.rd_data[ccmcfg_pkg::MAXP_W-1:0] = st.max_payload;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_RATE_SUBST)) begin
            next_st.rd_data[ccmcfg_pkg::RATE_W-1:0] = st.rate_subst;
         end

         if (hit(paddr, ccmcfg_pkg::OFS_STATUS)) begin
            next_st.rd_data[3:0] = st.seq;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st             <= '0;
         st.enable      <= ccmcfg_pkg::RST_ENABLE[1:0];
         st.dir         <= ccmcfg_pkg::RST_MODE[ccmcfg_pkg::DIR_BIT];
         st.key_ptr     <= ccmcfg_pkg::RST_PTR;
         st.src_ptr     <= ccmcfg_pkg::RST_PTR;
         st.dst_ptr     <= ccmcfg_pkg::RST_PTR;
         st.work_ptr    <= ccmcfg_pkg::RST_PTR;
         st.max_payload <= ccmcfg_pkg::RST_MAX_PAYLOAD;
         st.rate_subst  <= ccmcfg_pkg::RST_RATE_SUBST;
         st.s_dir       <= ccmcfg_pkg::DIR_DECRYPT;
         st.seq         <= S_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Request buffer and pacer
   // ------------------------------------------------------------
   ccmcfg_buf #(
      .WIDTH     (32)
   ) u_buf (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .in_data   (req_addr),
      .out_valid (mem_valid),
      .out_ready (mem_ready),
      .out_data  (mem_addr)
   );

   ccmcfg_pace #(
      .CNT_W     (14)
   ) u_pace (
      .pclk      (pclk),
      .presetn   (presetn),
      .run       (run),
      .rate      (st.s_rate),
      .tick      (byte_tick)
   );

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign pready      = 1'b1;
   assign pslverr     = 1'b0;
   assign prdata      = st.rd_data;
   assign engine_on   = run;
   assign op_decrypt  = st.s_dir;
   assign op_extended = st.s_len;
   assign op_rate     = st.s_rate;
   assign op_length   = st.s_length;
   assign op_busy     = (st.seq != S_IDLE);
endmodule : ccmcfg_top

//--- verification/ccmcfg_top_sva.sv
// Checker: port-level properties of the cipher configuration block
`timescale 1ns/1ps
module ccmcfg_top_sva #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Memory stream
   input wire logic              mem_valid,
   input wire logic              mem_ready,
   input wire logic [31:0]       mem_addr,
   // Engine settings
   input wire logic              engine_on,
   input wire logic              op_decrypt,
   input wire logic              op_extended,
   input wire logic [1:0]        op_rate,
   input wire logic [7:0]        op_length,
   input wire logic              byte_tick,
   input wire logic              op_busy
);
   // ------------------------------------------------------------
   // Shadow registers and tick gap counter
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic        wr, take, take_d, seen;
   logic [31:0] mode_s;
   logic [7:0]  maxp_s;
   logic [1:0]  rate_q;
   int          gap, per;
   assign wr = psel && penable && pwrite && pready;
   assign take = wr && paddr == ccmcfg_pkg::OFS_TASKS && pwdata[1:0] != 2'h0 && engine_on && !op_busy;
   always_comb begin
      case (op_rate)
         2'h0: per = ccmcfg_pkg::CYC_1M;
         2'h1: per = ccmcfg_pkg::CYC_2M;
         2'h2: per = ccmcfg_pkg::CYC_125K;
         default: per = ccmcfg_pkg::CYC_500K;
      endcase
   end
   // Phase check restarts after an accepted keystream or cipher task or a rate change, since the pacer may realign there
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_s <= 32'h0000_0001;
         maxp_s <= 8'hfb;
         take_d <= 1'b0;
         seen   <= 1'b0;
         rate_q <= 2'h0;
         gap    <= 0;
      end else begin
         if (wr && paddr == ccmcfg_pkg::OFS_OPERATION_MODE) mode_s <= pwdata;
         if (wr && paddr == ccmcfg_pkg::OFS_MAX_PAYLOAD) maxp_s <= pwdata[7:0];
         take_d <= take;
         rate_q <= op_rate;
         gap    <= byte_tick ? 0 : gap + 1;
         seen   <= (byte_tick || seen) && engine_on && !take && !take_d && op_rate == rate_q;
      end
   end
   property p_enable_on;
      wr && paddr == ccmcfg_pkg::OFS_ENGINE_ENABLE |=> engine_on == ($past(pwdata[1:0]) == 2'h2);
   endproperty
   a_enable_on: assert property (p_enable_on) else $error("engine state does not follow enable write");
   property p_off_idle;
      !engine_on |-> ##[0:2] !op_busy;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("sequencer busy while engine off");
   property p_no_tick_off;
      !engine_on |-> !byte_tick;
   endproperty
   a_no_tick_off: assert property (p_no_tick_off) else $error("byte tick while engine off");
   property p_dir;
      take |-> ##[1:2] op_decrypt == mode_s[ccmcfg_pkg::DIR_BIT];
   endproperty
   a_dir: assert property (p_dir) else $error("direction not sampled at task");
   property p_short_len;
      take && !mode_s[ccmcfg_pkg::LEN_BIT] |-> ##[1:2] (!op_extended && op_length == 8'h1b);
   endproperty
   a_short_len: assert property (p_short_len) else $error("default length keystream wrong");
   property p_ext_len;
      take && mode_s[ccmcfg_pkg::LEN_BIT] |-> ##[1:2] (op_extended && op_length == maxp_s);
   endproperty
   a_ext_len: assert property (p_ext_len) else $error("extended length keystream wrong");
   property p_op_hold;
      $changed({op_decrypt, op_extended, op_rate, op_length}) |-> $past(take) || $past(take, 2);
   endproperty
   a_op_hold: assert property (p_op_hold) else $error("settings changed without a task");
   property p_tick_period;
      seen |-> (byte_tick ? gap == per - 1 : gap < per - 1);
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("byte tick period wrong");
   property p_mem_hold;
      mem_valid && !mem_ready |=> mem_valid && $stable(mem_addr);
   endproperty
   a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped before accept");
endmodule : ccmcfg_top_sva

bind ccmcfg_top ccmcfg_top_sva #(.ADDR_W(ADDR_W)) u_sva (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_valid(mem_valid),
   .mem_ready(mem_ready), .mem_addr(mem_addr), .engine_on(engine_on), .op_decrypt(op_decrypt),
   .op_extended(op_extended), .op_rate(op_rate), .op_length(op_length), .byte_tick(byte_tick),
   .op_busy(op_busy));

//--- verification/ccmcfg_mem_model.sv
// Partner: system memory port that accepts request addresses with random stalls
`timescale 1ns/1ps
module ccmcfg_mem_model (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Memory stream
   input wire logic        mem_valid,
   input wire logic [31:0] mem_addr,
   output logic            mem_ready,
   // Test control
   input wire logic        stall
);
   logic [7:0]  lfsr;
   logic [31:0] last_addr;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lfsr      <= 8'h5a;
         mem_ready <= 1'b0;
         last_addr <= 32'h0000_0000;
      end else begin
         lfsr      <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
         mem_ready <= !stall && lfsr[0];
         if (mem_valid && mem_ready) last_addr <= mem_addr;
      end
   end
endmodule : ccmcfg_mem_model

//--- verification/ccmcfg_top_tb.sv
// Testbench: registers, tasks, settings and memory stream of the cipher configuration block
`timescale 1ns/1ps
module ccmcfg_top_tb;
   typedef struct packed {
      logic [31:0] a;
      logic        op;
      logic        dec;
      logic        ext;
      logic [1:0]  rate;
      logic [7:0]  len;
   } ccmcfg_exp_t;
   logic        pclk, presetn, psel, penable, pwrite, stall, pready, pslverr, mem_valid, mem_ready;
   logic        engine_on, op_decrypt, op_extended, byte_tick, op_busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mem_addr;
   logic [31:0] ptr [4];
   logic [31:0] rstv [8] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0000, 32'h0000_0000,
                             32'h0000_0000, 32'h0000_0000, 32'h0000_00fb, 32'h0000_0000};
   logic [1:0]  op_rate;
   logic [7:0]  op_length, maxp;
   logic [31:0] rdq [$];
   ccmcfg_exp_t mq [$];
   ccmcfg_exp_t e;
   int          errors, comparisons, n, k, seed;
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   ccmcfg_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr), .engine_on(engine_on),
      .op_decrypt(op_decrypt), .op_extended(op_extended), .op_rate(op_rate), .op_length(op_length),
      .byte_tick(byte_tick), .op_busy(op_busy));
   ccmcfg_mem_model partner (.pclk(pclk), .presetn(presetn), .mem_valid(mem_valid), .mem_addr(mem_addr),
      .mem_ready(mem_ready), .stall(stall));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic final_report;
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int j;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      j = 0;
      do begin
         @(posedge pclk);
         j++;
      end while (pready !== 1'b1 && j < 50);
      if (j >= 50) begin
         errors++;
         final_report();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      rdq.push_back(x);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd
   // Hold keeps the far side stalled so a second task meets a busy sequencer
   task automatic fire(input logic [1:0] cmd, input logic dir, input logic ext, input logic [1:0] rate,
                       input logic [1:0] xrate, input logic hold);
      maxp = 8'($urandom_range(255, 28));
      apb(1'b1, 12'h518, {24'h0, maxp});
      apb(1'b1, 12'h504, {7'h0, ext, 6'h0, rate, 15'h0, dir});
      mq.push_back({ptr[0], 1'b1, dir, ext, xrate, ext ? maxp : 8'h1b});
      mq.push_back({ptr[1], 13'h0});
      mq.push_back({ptr[2], 13'h0});
      stall <= hold;
      apb(1'b1, 12'h000, {30'h0, cmd});
      if (hold) begin
         apb(1'b1, 12'h000, {30'h0, cmd});
         repeat (10) @(posedge pclk);
         check({31'h0, mem_valid}, 32'h0000_0001);
         stall <= 1'b0;
      end
      for (k = 0; k < 300 && (mq.size() != 0 || op_busy !== 1'b0); k++) @(posedge pclk);
      if (k >= 300) begin
         errors++;
         final_report();
      end
   endtask : fire
   // ------------------------------------------------------------
   // Monitor and main sequence
   // ------------------------------------------------------------
   always @(posedge pclk) begin
      if (psel && penable && !pwrite && pready === 1'b1) check(prdata, rdq.pop_front());
      if (psel && penable && pready === 1'b1) check({31'h0, pslverr}, 32'h0000_0000);
      if (presetn && mem_valid === 1'b1 && mem_ready) begin
         if (mq.size() == 0) begin
            errors++;
            $display("ERROR %0t unexpected memory request", $time);
         end else begin
            e = mq.pop_front();
            check(mem_addr, e.a);
            if (e.op) check({20'h0, op_decrypt, op_extended, op_rate, op_length},
                            {20'h0, e.dec, e.ext, e.rate, e.len});
         end
      end
   end
   initial begin
      {psel, penable, pwrite, stall, presetn} = 5'h0;
      paddr  = 12'h000;
      pwdata = 32'h0000_0000;
      seed   = $urandom(28556);
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({31'h0, op_decrypt}, 32'h0000_0001);
      for (int i = 0; i < 8; i++) rd(12'h500 + 12'(4 * i), rstv[i]);
      apb(1'b1, 12'h600, $urandom());
      rd(12'h600, 32'h0000_0000);
      // Work area is sized by software; the model memory has no bound
      for (int i = 0; i < 4; i++) begin
         ptr[i] = $urandom();
         apb(1'b1, 12'h508 + 12'(4 * i), ptr[i]);
         rd(12'h508 + 12'(4 * i), ptr[i]);
      end
      apb(1'b1, 12'h500, 32'h0000_0001);
      apb(1'b1, 12'h000, 32'h0000_0001);
      repeat (20) @(posedge pclk);
      check({31'h0, engine_on}, 32'h0000_0000);
      apb(1'b1, 12'h500, 32'h0000_0002);
      @(posedge pclk);
      check({31'h0, engine_on}, 32'h0000_0001);
      for (int i = 0; i < 8; i++) begin
         fire(i[0] ? 2'h2 : 2'h1, i[2], i[0] ^ i[2], 2'(i), 2'(i), i == 5);
         for (k = 0, n = 0; i < 4 && n < 3 && k < 30000; k++) begin
            @(posedge pclk);
            if (byte_tick === 1'b1) n++;
         end
         if (i < 4) check(32'(n), 32'h0000_0003);
      end
      apb(1'b1, 12'h51c, 32'h0000_0003);
      apb(1'b1, 12'h000, 32'h0000_0004);
      fire(2'h1, 1'b0, 1'b0, 2'h0, 2'h3, 1'b0);
      fire(2'h2, 1'b1, 1'b0, 2'h0, 2'h0, 1'b0);
      apb(1'b1, 12'h500, 32'h0000_0000);
      @(posedge pclk);
      check({31'h0, engine_on}, 32'h0000_0000);
      final_report();
   end
endmodule : ccmcfg_top_tb
